// ---- rtl/bsf_device.sv ----
// fifo device end: two queues, bypass registers, flags and offsets
`timescale 1ns/1ns
`default_nettype none
module bsf_device
  import bsf_pkg::*;
(
  input wire logic clk_sys_in, // system clock, both ports
  input wire logic rst_in, // async reset, high active
  bsf_link_if.dev link, // pins to the port masters
  output logic [CW-1:0] a2b_level_out, // A-to-B word count
  output logic [CW-1:0] b2a_level_out // B-to-A word count
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [AW-1:0] ab_wp, ab_rp, ba_wp, ba_rp; // queue pointers
    logic [CW-1:0] ab_cnt, ba_cnt; // word counts
    logic [CW-1:0] ab_ae_ofs, ab_af_ofs, ba_ae_ofs, ba_af_ofs; // flag offsets
    logic bypass; // bypass mode
    logic [DW-1:0] ab_byp, ba_byp; // bypass output registers
    logic ab_byp_full, ba_byp_full; // bypass message held
    logic [DW-1:0] a_rdata, b_rdata; // port output registers
    logic ab_ef_n, ab_ae_n, ab_af_n, ab_ff_n; // A-to-B flags
    logic ba_ef_n, ba_ae_n, ba_af_n, ba_ff_n; // B-to-A flags
    logic byp_n; // bypass indicator
  } bsf_dev_state_type;

  bsf_dev_state_type r; // registered state
  bsf_dev_state_type next_r; // next state
  logic [DW-1:0] ab_mem [0:DEPTH-1]; // A-to-B storage
  logic [DW-1:0] ba_mem [0:DEPTH-1]; // B-to-A storage
  logic a_act, a_wr, a_rd, a_q; // port A decode
  logic b_act, b_wr, b_rd; // port B decode
  logic ab_push, ab_pop, ba_push, ba_pop; // queue moves

  // reset image of the state
  function automatic bsf_dev_state_type rst_state();
    bsf_dev_state_type s;
    s = '0;
    s.ab_ae_ofs = OFS_DEFAULT;
    s.ab_af_ofs = OFS_DEFAULT;
    s.ba_ae_ofs = OFS_DEFAULT;
    s.ba_af_ofs = OFS_DEFAULT;
    s.ab_af_n = 1'b1;
    s.ab_ff_n = 1'b1;
    s.ba_af_n = 1'b1;
    s.ba_ff_n = 1'b1;
    s.byp_n = 1'b1;
    return s;
  endfunction

  // ==========================================================
  // port decode
  always_comb
  begin
    a_act = !link.porta_sel_n && !link.porta_xfer_en_n;
    a_wr = a_act && !link.porta_dir_sel;
    a_rd = a_act && link.porta_dir_sel;
    a_q = link.porta_res_sel == RES_QUEUE;
    b_act = !link.portb_xfer_en_n;
    // direction select picks write or read
    b_wr = b_act && !link.portb_dir_sel;
    b_rd = b_act && link.portb_dir_sel;
    // full flag blocks port A writes
    ab_push = !r.bypass && a_wr && a_q && r.ab_ff_n;
    // empty flag blocks port B reads
    ab_pop = !r.bypass && b_rd && r.ab_ef_n;
    // full flag blocks port B writes
    ba_push = !r.bypass && b_wr && r.ba_ff_n;
    // empty flag blocks port A reads
    ba_pop = !r.bypass && a_rd && a_q && r.ba_ef_n;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_r = r;
    // pointers and counts
    if (ab_push)
    begin
      next_r.ab_wp = r.ab_wp + 1'b1;
    end
    if (ab_pop)
    begin
      next_r.ab_rp = r.ab_rp + 1'b1;
      next_r.b_rdata = ab_mem[r.ab_rp];
    end
    if (ba_push)
    begin
      next_r.ba_wp = r.ba_wp + 1'b1;
    end
    if (ba_pop)
    begin
      next_r.ba_rp = r.ba_rp + 1'b1;
      next_r.a_rdata = ba_mem[r.ba_rp];
    end
    next_r.ab_cnt = r.ab_cnt + CW'(ab_push) - CW'(ab_pop);
    next_r.ba_cnt = r.ba_cnt + CW'(ba_push) - CW'(ba_pop);
    // port A resource writes
    if (a_wr)
    begin
      case (link.porta_res_sel)
        RES_AB_AE: next_r.ab_ae_ofs = link.porta_bus[CW-1:0];
        RES_AB_AF: next_r.ab_af_ofs = link.porta_bus[CW-1:0];
        RES_BA_AE: next_r.ba_ae_ofs = link.porta_bus[CW-1:0];
        RES_BA_AF: next_r.ba_af_ofs = link.porta_bus[CW-1:0];
        RES_CTRL: next_r.bypass = link.porta_bus[CTRL_BYPASS_BIT];
        default: next_r.bypass = r.bypass; // queue handled above
      endcase
    end
    // port A resource reads
    if (a_rd)
    begin
      case (link.porta_res_sel)
        RES_AB_AE: next_r.a_rdata = DW'(r.ab_ae_ofs);
        RES_AB_AF: next_r.a_rdata = DW'(r.ab_af_ofs);
        RES_BA_AE: next_r.a_rdata = DW'(r.ba_ae_ofs);
        RES_BA_AF: next_r.a_rdata = DW'(r.ba_af_ofs);
        RES_CTRL: next_r.a_rdata = DW'(r.bypass);
        default: next_r.a_rdata = next_r.a_rdata; // queue handled above
      endcase
    end
    // bypass message passing
    if (r.bypass)
    begin
      // port A write loads A-to-B register
      if (a_wr && a_q && !r.ab_byp_full)
      begin
        next_r.ab_byp = link.porta_bus;
        next_r.ab_byp_full = 1'b1;
      end
      // port B read takes A-to-B register
      if (b_rd && r.ab_byp_full)
      begin
        next_r.b_rdata = r.ab_byp;
        next_r.ab_byp_full = 1'b0;
      end
      // port B write loads B-to-A register
      if (b_wr && !r.ba_byp_full)
      begin
        next_r.ba_byp = link.portb_bus;
        next_r.ba_byp_full = 1'b1;
      end
      // port A read takes B-to-A register
      if (a_rd && a_q && r.ba_byp_full)
      begin
        next_r.a_rdata = r.ba_byp;
        next_r.ba_byp_full = 1'b0;
      end
    end
    // empty flags registered on the reading side
    next_r.ab_ef_n = next_r.ab_cnt != '0;
    next_r.ba_ef_n = next_r.ba_cnt != '0;
    next_r.ab_ae_n = next_r.ab_cnt > next_r.ab_ae_ofs;
    next_r.ba_ae_n = next_r.ba_cnt > next_r.ba_ae_ofs;
    next_r.ab_af_n = next_r.ab_cnt <= DEPTH - next_r.ab_af_ofs;
    next_r.ba_af_n = next_r.ba_cnt <= DEPTH - next_r.ba_af_ofs;
    // full flags registered on the writing side
    next_r.ab_ff_n = next_r.ab_cnt != DEPTH;
    next_r.ba_ff_n = next_r.ba_cnt != DEPTH;
    if (next_r.bypass)
    begin
      // A-to-B empty shows a waiting message
      next_r.ab_ef_n = next_r.ab_byp_full;
      next_r.ab_ff_n = !next_r.ab_byp_full;
      // B-to-A empty falls the cycle after the read
      next_r.ba_ef_n = next_r.ba_byp_full;
      next_r.ba_ff_n = !next_r.ba_byp_full;
    end
    next_r.byp_n = !next_r.bypass;
    if (!link.global_rst_n)
    begin
      next_r = rst_state();
    end
  end

  // ==========================================================
  // state registers
  // all transfers on the rising edge
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= rst_state();
    end
    else
    begin
      r <= next_r;
    end
  end

  // queue storage, no reset needed
  always_ff @(posedge clk_sys_in)
  begin
    if (ab_push)
    begin
      ab_mem[r.ab_wp] <= link.porta_bus;
    end
    if (ba_push)
    begin
      ba_mem[r.ba_wp] <= link.portb_bus;
    end
  end

  // ==========================================================
  // outputs
  assign link.porta_bus_dev = r.a_rdata;
  assign link.porta_bus_dev_oe = !link.porta_sel_n && link.porta_dir_sel && !link.porta_out_en_n;
  assign link.portb_bus_dev = r.b_rdata;
  // drive port B only when reading and enabled
  assign link.portb_bus_dev_oe = link.portb_dir_sel && !link.portb_out_en_n;
  assign link.a2b_empty_n = r.ab_ef_n;
  assign link.a2b_almost_empty_n = r.ab_ae_n;
  assign link.a2b_almost_full_n = r.ab_af_n;
  assign link.a2b_full_n = r.ab_ff_n;
  assign link.b2a_empty_n = r.ba_ef_n;
  assign link.b2a_almost_empty_n = r.ba_ae_n;
  assign link.b2a_almost_full_n = r.ba_af_n;
  assign link.b2a_full_n = r.ba_ff_n;
  assign link.portb_passthru_ind_n = r.byp_n;
  assign a2b_level_out = r.ab_cnt;
  assign b2a_level_out = r.ba_cnt;
endmodule
`default_nettype wire

// ---- rtl/bsf_pkg.sv ----
// constants shared by both ends of the bidirectional synchronous fifo
// Function
// - port B direction low writes, high reads
// - bypass moves port B messages through registers
// - port B transfers on rising clock edge
// - port B transfers only while enable low
// - port B drives bus when output enable low
// - A-to-B empty low blocks port B reads
// - bypass A-to-B empty high means word waiting
// - almost-empty low when count within offset
// - almost-full low when count above depth-offset
// - empty flags registered on reading port clock
// - full flags registered on writing port clock
// - A-to-B full low blocks port A writes
// - bypass A-to-B full low means message unread
// - B-to-A empty low blocks port A reads
// - bypass B-to-A empty falls after port A read
// - B-to-A full low blocks port B writes
// - bypass B-to-A full low means message unread
// - bypass indicator low while in bypass mode
// - global reset low reinitializes everything
// - port A active only while select low
// - port A select and address choose resource
// - bypass moves port A messages through registers
package bsf_pkg;
  // ==========================================================
  // widths and depth
  localparam int DW = 18; // data bus width
  localparam int AW = 8; // queue pointer width
  localparam int CW = 9; // word count width
  localparam logic [CW-1:0] DEPTH = 9'h100; // words per queue
  localparam logic [CW-1:0] OFS_DEFAULT = 9'h008; // offset reset value
  // ==========================================================
  // port A resource codes
  localparam logic [2:0] RES_QUEUE = 3'h0; // queue data
  localparam logic [2:0] RES_AB_AE = 3'h1; // A-to-B almost-empty offset
  localparam logic [2:0] RES_AB_AF = 3'h2; // A-to-B almost-full offset
  localparam logic [2:0] RES_BA_AE = 3'h3; // B-to-A almost-empty offset
  localparam logic [2:0] RES_BA_AF = 3'h4; // B-to-A almost-full offset
  localparam logic [2:0] RES_CTRL = 3'h5; // mode control
  localparam int CTRL_BYPASS_BIT = 0; // bypass enable bit
endpackage

// ---- rtl/bsf_link_if.sv ----
// pin bundle between the fifo device and its two port masters
`timescale 1ns/1ns
`default_nettype none
interface bsf_link_if;
  import bsf_pkg::*;
  // ==========================================================
  // port A pins
  logic porta_sel_n; // chip select, low active
  logic porta_dir_sel; // low write, high read
  logic porta_xfer_en_n; // transfer enable, low active
  logic porta_out_en_n; // output enable, low active
  logic [2:0] porta_res_sel; // resource address
  logic [DW-1:0] porta_bus_host; // master drive value
  logic porta_bus_host_oe; // master drives bus
  logic [DW-1:0] porta_bus_dev; // device drive value
  logic porta_bus_dev_oe; // device drives bus
  logic [DW-1:0] porta_bus; // resolved bus level
  // ==========================================================
  // port B pins
  logic portb_dir_sel; // low write, high read
  logic portb_xfer_en_n; // transfer enable, low active
  logic portb_out_en_n; // output enable, low active
  logic [DW-1:0] portb_bus_host; // master drive value
  logic portb_bus_host_oe; // master drives bus
  logic [DW-1:0] portb_bus_dev; // device drive value
  logic portb_bus_dev_oe; // device drives bus
  logic [DW-1:0] portb_bus; // resolved bus level
  // ==========================================================
  // flags and reset
  logic a2b_empty_n, a2b_almost_empty_n, a2b_almost_full_n, a2b_full_n; // A-to-B flags
  logic b2a_empty_n, b2a_almost_empty_n, b2a_almost_full_n, b2a_full_n; // B-to-A flags
  logic portb_passthru_ind_n; // bypass indicator
  logic global_rst_n; // device reset, low active
  // undriven bus reads as zero
  assign porta_bus = porta_bus_dev_oe ? porta_bus_dev : (porta_bus_host_oe ? porta_bus_host : '0);
  assign portb_bus = portb_bus_dev_oe ? portb_bus_dev : (portb_bus_host_oe ? portb_bus_host : '0);
  modport dev (
    input porta_sel_n, porta_dir_sel, porta_xfer_en_n, porta_out_en_n, porta_res_sel, porta_bus,
    input portb_dir_sel, portb_xfer_en_n, portb_out_en_n, portb_bus, global_rst_n,
    output porta_bus_dev, porta_bus_dev_oe, portb_bus_dev, portb_bus_dev_oe,
    output a2b_empty_n, a2b_almost_empty_n, a2b_almost_full_n, a2b_full_n,
    output b2a_empty_n, b2a_almost_empty_n, b2a_almost_full_n, b2a_full_n, portb_passthru_ind_n
  );
  modport host (
    output porta_sel_n, porta_dir_sel, porta_xfer_en_n, porta_out_en_n, porta_res_sel,
    output portb_dir_sel, portb_xfer_en_n, portb_out_en_n, global_rst_n,
    output porta_bus_host, porta_bus_host_oe, portb_bus_host, portb_bus_host_oe,
    input porta_bus, portb_bus,
    input a2b_empty_n, a2b_almost_empty_n, a2b_almost_full_n, a2b_full_n,
    input b2a_empty_n, b2a_almost_empty_n, b2a_almost_full_n, b2a_full_n, portb_passthru_ind_n
  );
endinterface
`default_nettype wire

// ---- rtl/bsf_host.sv ----
// port master end: drives port A and port B pins from user requests
`timescale 1ns/1ns
`default_nettype none
module bsf_host
  import bsf_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset, high active
  bsf_link_if.host link, // pins to the device
  input wire logic dev_rst_req_in, // pulls device reset pin low
  input wire logic a_req_in, // port A request
  input wire logic a_dir_in, // port A: 0 write, 1 read
  input wire logic [2:0] a_res_in, // port A resource
  input wire logic [DW-1:0] a_wdata_in, // port A write data
  output logic a_ready_out, // port A request taken
  output logic [DW-1:0] a_rdata_out, // port A read data
  output logic a_rvalid_out, // port A read data pulse
  input wire logic b_req_in, // port B request
  input wire logic b_dir_in, // port B: 0 write, 1 read
  input wire logic [DW-1:0] b_wdata_in, // port B write data
  output logic b_ready_out, // port B request taken
  output logic [DW-1:0] b_rdata_out, // port B read data
  output logic b_rvalid_out // port B read data pulse
);
  // ==========================================================
  // state
  typedef struct packed {
    logic a_pend, b_pend; // read data due on bus
    logic a_dir, b_dir; // last direction driven
    logic [DW-1:0] a_rdata, b_rdata; // captured read data
    logic a_rvalid, b_rvalid; // capture pulses
  } bsf_host_state_type;

  bsf_host_state_type r; // registered state
  bsf_host_state_type next_r; // next state
  logic a_ok, b_ok, a_go, b_go; // request gating

  // ==========================================================
  // request gating
  always_comb
  begin
    a_ok = 1'b1;
    // no queue write while A-to-B full
    if (a_res_in == RES_QUEUE && !a_dir_in)
    begin
      a_ok = link.a2b_full_n;
    end
    // no queue read while B-to-A empty
    if (a_res_in == RES_QUEUE && a_dir_in)
    begin
      a_ok = link.b2a_empty_n;
    end
    b_ok = b_dir_in ? link.a2b_empty_n : link.b2a_full_n;
    // a write may not turn the bus while read data is due
    a_ready_out = a_ok && !(r.a_pend && !a_dir_in);
    b_ready_out = b_ok && !(r.b_pend && !b_dir_in);
    a_go = a_req_in && a_ready_out;
    b_go = b_req_in && b_ready_out;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_r = r;
    next_r.a_pend = a_go && a_dir_in;
    next_r.b_pend = b_go && b_dir_in;
    next_r.a_dir = a_go ? a_dir_in : r.a_dir;
    next_r.b_dir = b_go ? b_dir_in : r.b_dir;
    next_r.a_rvalid = r.a_pend;
    next_r.b_rvalid = r.b_pend;
    if (r.a_pend)
    begin
      next_r.a_rdata = link.porta_bus;
    end
    if (r.b_pend)
    begin
      next_r.b_rdata = link.portb_bus;
    end
  end

  // state registers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================================
  // pins
  // select low only around a transfer
  assign link.porta_sel_n = !(a_go || r.a_pend);
  assign link.porta_dir_sel = a_go ? a_dir_in : r.a_dir;
  assign link.porta_xfer_en_n = !a_go;
  assign link.porta_out_en_n = !link.porta_dir_sel;
  assign link.porta_res_sel = a_res_in;
  assign link.porta_bus_host = a_wdata_in;
  assign link.porta_bus_host_oe = a_go && !a_dir_in;
  assign link.portb_dir_sel = b_go ? b_dir_in : r.b_dir;
  // enable low only for a taken request
  assign link.portb_xfer_en_n = !b_go;
  assign link.portb_out_en_n = !link.portb_dir_sel;
  assign link.portb_bus_host = b_wdata_in;
  assign link.portb_bus_host_oe = b_go && !b_dir_in;
  assign link.global_rst_n = !dev_rst_req_in;
  assign a_rdata_out = r.a_rdata;
  assign a_rvalid_out = r.a_rvalid;
  assign b_rdata_out = r.b_rdata;
  assign b_rvalid_out = r.b_rvalid;
endmodule
`default_nettype wire

// ---- test/bsf_link_checker.sv ----
// assertions watching the pin bundle between the fifo device and its masters
`timescale 1ns/1ns
`default_nettype none
module bsf_link_checker
  import bsf_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset
  input wire logic porta_sel_n, // port A select
  input wire logic porta_dir_sel, // port A direction
  input wire logic porta_xfer_en_n, // port A enable
  input wire logic porta_out_en_n, // port A output enable
  input wire logic [2:0] porta_res_sel, // port A resource
  input wire logic porta_bus_dev_oe, // device drives A
  input wire logic portb_dir_sel, // port B direction
  input wire logic portb_xfer_en_n, // port B enable
  input wire logic portb_out_en_n, // port B output enable
  input wire logic portb_bus_dev_oe, // device drives B
  input wire logic a2b_empty_n, // A-to-B empty
  input wire logic a2b_almost_empty_n, // A-to-B almost empty
  input wire logic a2b_almost_full_n, // A-to-B almost full
  input wire logic a2b_full_n, // A-to-B full
  input wire logic b2a_empty_n, // B-to-A empty
  input wire logic b2a_almost_empty_n, // B-to-A almost empty
  input wire logic b2a_almost_full_n, // B-to-A almost full
  input wire logic b2a_full_n, // B-to-A full
  input wire logic portb_passthru_ind_n, // bypass indicator
  input wire logic global_rst_n // device reset pin
);
  // ==========================================================
  // transfer decode and short history
  logic a_acc, a_qwr, a_qrd, b_wr, b_rd; // decoded transfers
  logic [1:0] wr_h, rs_h; // port A write and reset history
  assign a_acc = !porta_sel_n && !porta_xfer_en_n;
  assign a_qwr = a_acc && !porta_dir_sel && porta_res_sel == RES_QUEUE;
  assign a_qrd = a_acc && porta_dir_sel && porta_res_sel == RES_QUEUE;
  assign b_wr = !portb_xfer_en_n && !portb_dir_sel;
  assign b_rd = !portb_xfer_en_n && portb_dir_sel;
  // shift the last two cycles of port A writes and device resets
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_h <= 2'h0;
      rs_h <= 2'h0;
    end
    else
    begin
      wr_h <= {wr_h[0], a_acc && !porta_dir_sel};
      rs_h <= {rs_h[0], !global_rst_n};
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // named steps
  sequence s_reset_image;
    !a2b_empty_n && !a2b_almost_empty_n && a2b_almost_full_n && a2b_full_n && !b2a_empty_n
      && !b2a_almost_empty_n && b2a_almost_full_n && b2a_full_n && portb_passthru_ind_n;
  endsequence
  sequence s_bypass_b_read;
    !portb_passthru_ind_n && b_rd && a2b_empty_n && global_rst_n;
  endsequence
  sequence s_bypass_a_read;
    !portb_passthru_ind_n && a_qrd && b2a_empty_n && global_rst_n;
  endsequence
  // ==========================================================
  // assertions
  // port A drive gated
  chk_porta_drive: assert property (porta_bus_dev_oe |-> !porta_sel_n && porta_dir_sel && !porta_out_en_n)
    else $error("port A bus driven while not selected for read");
  chk_portb_drive: assert property (portb_bus_dev_oe |-> portb_dir_sel && !portb_out_en_n)
    else $error("port B bus driven while not reading");
  chk_portb_drives: assert property (portb_dir_sel && !portb_out_en_n |-> portb_bus_dev_oe)
    else $error("port B bus left floating while reading");
  chk_a2b_empty_hold: assert property (!a2b_empty_n && !a_acc |=> !a2b_empty_n)
    else $error("A-to-B empty left without a port A write");
  chk_b2a_empty_hold: assert property (!b2a_empty_n && !b_wr && !a_acc |=> !b2a_empty_n)
    else $error("B-to-A empty left without a port B write");
  // full holds until port B reads
  chk_a2b_full_hold: assert property (!a2b_full_n && !b_rd && !a_acc && global_rst_n |=> !a2b_full_n)
    else $error("A-to-B full released without a port B read");
  chk_b_write_fills: assert property (b_wr && b2a_full_n && global_rst_n |=> b2a_empty_n)
    else $error("port B write did not reach the B-to-A side");
  chk_a_write_fills: assert property (a_qwr && a2b_full_n && global_rst_n |=> a2b_empty_n)
    else $error("port A write did not reach the A-to-B side");
  chk_dev_reset_image: assert property (!global_rst_n |=> s_reset_image)
    else $error("flags not at reset levels after device reset");
  // indicator moves only after a port A write or a device reset
  chk_passthru_cause: assert property ($changed(portb_passthru_ind_n) |-> wr_h != 2'h0 || rs_h != 2'h0)
    else $error("bypass indicator moved without cause");
  chk_bypass_b_read: assert property (s_bypass_b_read |=> !a2b_empty_n && a2b_full_n)
    else $error("bypass port B read did not release the message");
  chk_bypass_a_read: assert property (s_bypass_a_read |=> !b2a_empty_n && b2a_full_n)
    else $error("bypass port A read did not release the message");
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench: both fifo ends joined through the link bundle
`timescale 1ns/1ns
`default_nettype none
module testbench
  import bsf_pkg::*;
;
  logic clk_sys_in, rst_in, dev_rst_req; // clock and resets
  logic a_req, a_dir, b_req, b_dir, a_ready, a_rvalid, b_ready, b_rvalid; // user handshakes
  logic [2:0] a_res; // port A resource
  logic [DW-1:0] a_wdata, b_wdata, a_rdata, b_rdata, rd; // user data
  logic [CW-1:0] a2b_level, b2a_level; // word counts
  logic [8:0] flags; // all flag pins packed
  int n_fail, num_checks, i; // tallies and loop index
  bsf_link_if link();
  assign flags = {link.a2b_empty_n, link.a2b_almost_empty_n, link.a2b_almost_full_n, link.a2b_full_n,
    link.b2a_empty_n, link.b2a_almost_empty_n, link.b2a_almost_full_n, link.b2a_full_n, link.portb_passthru_ind_n};
  bsf_device u_bsf_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link),
    .a2b_level_out(a2b_level), .b2a_level_out(b2a_level));
  bsf_host u_bsf_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link), .dev_rst_req_in(dev_rst_req),
    .a_req_in(a_req), .a_dir_in(a_dir), .a_res_in(a_res), .a_wdata_in(a_wdata), .a_ready_out(a_ready),
    .a_rdata_out(a_rdata), .a_rvalid_out(a_rvalid), .b_req_in(b_req), .b_dir_in(b_dir),
    .b_wdata_in(b_wdata), .b_ready_out(b_ready), .b_rdata_out(b_rdata), .b_rvalid_out(b_rvalid));
  bsf_link_checker u_bsf_link_checker (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .porta_sel_n(link.porta_sel_n), .porta_dir_sel(link.porta_dir_sel), .porta_xfer_en_n(link.porta_xfer_en_n),
    .porta_out_en_n(link.porta_out_en_n), .porta_res_sel(link.porta_res_sel),
    .porta_bus_dev_oe(link.porta_bus_dev_oe), .portb_dir_sel(link.portb_dir_sel),
    .portb_xfer_en_n(link.portb_xfer_en_n), .portb_out_en_n(link.portb_out_en_n),
    .portb_bus_dev_oe(link.portb_bus_dev_oe), .a2b_empty_n(link.a2b_empty_n),
    .a2b_almost_empty_n(link.a2b_almost_empty_n), .a2b_almost_full_n(link.a2b_almost_full_n),
    .a2b_full_n(link.a2b_full_n), .b2a_empty_n(link.b2a_empty_n), .b2a_almost_empty_n(link.b2a_almost_empty_n),
    .b2a_almost_full_n(link.b2a_almost_full_n), .b2a_full_n(link.b2a_full_n),
    .portb_passthru_ind_n(link.portb_passthru_ind_n), .global_rst_n(link.global_rst_n));
  // ==========================================================
  // clock, 100 ns period
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // ==========================================================
  // report, compare and transfer tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // flags compared one settled cycle later
  task automatic chkf(input logic [8:0] exp);
    @(negedge clk_sys_in);
    chk({9'h000, flags}, {9'h000, exp});
  endtask
  // one user transfer on port A or B; read data lands in rd
  task automatic op(input logic pb, input logic dir, input logic [2:0] res, input logic [DW-1:0] wd);
    int k;
    @(negedge clk_sys_in);
    a_req = !pb;
    b_req = pb;
    a_dir = dir;
    b_dir = dir;
    a_res = res;
    a_wdata = wd;
    b_wdata = wd;
    #1;
    k = 0;
    // hold the request until the edge that takes it
    while ((pb ? b_ready : a_ready) !== 1'b1 && k < 40)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    @(negedge clk_sys_in);
    a_req = 1'b0;
    b_req = 1'b0;
    // reads wait for the data pulse
    while (dir && (pb ? b_rvalid : a_rvalid) !== 1'b1 && k < 40)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    rd = pb ? b_rdata : a_rdata;
    if (k >= 40)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: no answer on the link", $time);
      wrap_up();
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rst_in = 1'b1;
    {dev_rst_req, a_req, b_req, a_dir, b_dir, a_res, a_wdata, b_wdata} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chkf(9'h067);
    for (i = 1; i <= 5; i++)
    begin
      op(1'b0, 1'b1, i[2:0], 18'h0_0000);
      chk(rd, (i == 5) ? 18'h0_0000 : 18'h0_0008);
    end
    // unmapped write must not disturb offsets
    op(1'b0, 1'b0, 3'h7, 18'h3_ffff);
    op(1'b0, 1'b1, RES_AB_AE, 18'h0_0000);
    chk(rd, 18'h0_0008);
    // almost-empty boundary at default offset
    for (i = 0; i < 9; i++)
    begin
      op(1'b0, 1'b0, RES_QUEUE, 18'h1_0000 + 18'(i));
      if (i == 7)
        chkf(9'h167);
    end
    chkf(9'h1e7);
    chk({9'h000, a2b_level}, 18'h0_0009);
    for (i = 0; i < 9; i++)
    begin
      op(1'b1, 1'b1, RES_QUEUE, 18'h0_0000);
      chk(rd, 18'h1_0000 + 18'(i));
    end
    chkf(9'h067);
    // programmed almost-empty offset of 2
    op(1'b0, 1'b0, RES_AB_AE, 18'h0_0002);
    repeat (3) op(1'b0, 1'b0, RES_QUEUE, 18'h0_0005);
    chkf(9'h1e7);
    op(1'b1, 1'b1, RES_QUEUE, 18'h0_0000);
    chkf(9'h167);
    repeat (2) op(1'b1, 1'b1, RES_QUEUE, 18'h0_0000);
    // fill B-to-A through the almost-full boundary to full
    for (i = 0; i < 256; i++)
    begin
      op(1'b1, 1'b0, RES_QUEUE, 18'h2_0000 + 18'(i));
      if (i == 247)
        chkf(9'h07f);
      if (i == 248)
        chkf(9'h07b);
    end
    chkf(9'h079);
    // a write offered while full is held off
    @(negedge clk_sys_in);
    b_req = 1'b1;
    b_dir = 1'b0;
    repeat (3)
    begin
      @(negedge clk_sys_in);
      chk({17'h0_0000, b_ready}, 18'h0_0000);
    end
    b_req = 1'b0;
    chk({9'h000, b2a_level}, 18'h0_0100);
    for (i = 0; i < 256; i++)
    begin
      op(1'b0, 1'b1, RES_QUEUE, 18'h0_0000);
      chk(rd, 18'h2_0000 + 18'(i));
    end
    chkf(9'h067);
    // programmed B-to-A offsets at their extremes
    op(1'b0, 1'b0, RES_BA_AE, 18'h0_0000);
    op(1'b0, 1'b0, RES_BA_AF, 18'h0_0100);
    op(1'b1, 1'b0, RES_QUEUE, 18'h0_0042);
    chkf(9'h07b);
    op(1'b0, 1'b1, RES_QUEUE, 18'h0_0000);
    chk(rd, 18'h0_0042);
    chkf(9'h067);
    // bypass messages in both directions
    op(1'b0, 1'b0, RES_CTRL, 18'h0_0001);
    chkf(9'h066);
    op(1'b0, 1'b0, RES_QUEUE, 18'h0_0abc);
    chkf(9'h146);
    op(1'b1, 1'b1, RES_QUEUE, 18'h0_0000);
    chk(rd, 18'h0_0abc);
    chkf(9'h066);
    op(1'b1, 1'b0, RES_QUEUE, 18'h1_2345);
    chkf(9'h074);
    op(1'b0, 1'b1, RES_QUEUE, 18'h0_0000);
    chk(rd, 18'h1_2345);
    chkf(9'h066);
    // device reset pin in mid-run clears bypass, data and offsets
    op(1'b0, 1'b0, RES_QUEUE, 18'h0_0077);
    op(1'b0, 1'b0, RES_AB_AF, 18'h0_0010);
    @(negedge clk_sys_in);
    dev_rst_req = 1'b1;
    @(negedge clk_sys_in);
    dev_rst_req = 1'b0;
    chkf(9'h067);
    op(1'b0, 1'b1, RES_AB_AF, 18'h0_0000);
    chk(rd, 18'h0_0008);
    chk({9'h000, a2b_level}, 18'h0_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
